/* File: rtl/clock_divider_reset_sync.sv */
`include "clock_divider_reset_sync_consts.svh"

// Overview of operation
// - divide source by two, 50% duty
// - all timing from divided clock, driven out
// - output toggles only on source falling edges, except the forced rise on the source rise that starts a clear
// - raw oscillator never reaches any pin
// - reset input clears the divider phase
// - clear pulse spans two source rising edges
// - system clock held high during clear
// - low on next fall, then toggle each fall
// - resets registered on system clock fall
// - resets held while reset input active
// - first fetch 6.5 cycles later, at FFFF0
module clock_divider_reset_sync
   import clock_divider_reset_sync_pkg::*;
#(
   parameter int FETCH_HALVES = `FETCH_DELAY_HALVES
)
(
   input  wire logic                     clk,
   input  wire logic                     rst_n,
   input  wire logic                     osc_in,
   input  wire logic                     ext_freq_in,
   input  wire logic                     use_ext_freq,
   input  wire logic                     async_reset_in_n,
   output logic                          sys_clock_out,
   output logic                          sys_fall_en,
   output logic                          int_reset,
   output logic                          reset_out,
   output logic                          fetch_start,
   output logic [`FETCH_ADDR_W-1:0]      fetch_addr
);
   localparam int CNT_W = $clog2(FETCH_HALVES + 1);
   localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(FETCH_HALVES - 1);
   // bound on the wait for the first source rise after a request
   localparam int CLEAR_BOUND = `CLEAR_START_BOUND;

   gen_state_e          state_reg;
   gen_state_e          state_next;
   logic                src_reg;
   logic                clk_reg;
   logic                clk_next;
   logic [CNT_W-1:0]    cnt_reg;
   logic [CNT_W-1:0]    cnt_next;
   logic                fetch_reg;
   logic                fetch_next;
   logic [`FETCH_ADDR_W-1:0] addr_reg;

   wire  src        = use_ext_freq ? ext_freq_in : osc_in;
   wire  src_rise   = src & ~src_reg;
   wire  src_fall   = ~src & src_reg;
   wire  clear_act  = (state_reg == st_clear);
   wire  clear_nxt  = (state_next == st_clear);
   wire  sys_toggle = src_fall & ~clear_nxt;
   wire  sys_fall   = sys_toggle & clk_reg;
   wire  reset_req  = ~async_reset_in_n;
   wire  last_half  = (cnt_reg == CNT_LAST);

   reset_sync_if rs ();

   // falling edge of the system clock steps the reset stages
   assign rs.sys_fall_en = sys_fall;
   assign rs.reset_req   = reset_req;

   reset_synchroniser u_sync
   (
      .clk   (clk),
      .rst_n (rst_n),
      .rs    (rs)
   );

   // the same synchronised level feeds the core and the pin
   assign int_reset     = rs.reset_sync;
   assign reset_out     = rs.reset_sync;
   // only the divided clock leaves the block, never the source
   assign sys_clock_out = clk_reg;
   assign sys_fall_en   = sys_fall;
   assign fetch_start   = fetch_reg;
   assign fetch_addr    = addr_reg;

   // reset sequence: arm, clear pulse, hold, count to first fetch
   always_comb
   begin
      state_next = state_reg;
      cnt_next   = cnt_reg;
      fetch_next = 1'b0;
      unique case (state_reg)
         st_run:
            if (reset_req)
               state_next = st_arm;
         st_arm:
            if (src_rise)
               state_next = st_clear;
         st_clear:
            if (src_rise)
               state_next = st_hold;
         st_hold:
            if (!reset_req)
            begin
               state_next = st_count;
               cnt_next   = '0;
            end
         st_count:
            // a fresh reset assertion restarts the whole sequence
            if (reset_req)
               state_next = st_arm;
            else if (sys_toggle)
            begin
               if (last_half)
               begin
                  state_next = st_run;
                  fetch_next = 1'b1;
               end
               else
                  cnt_next = cnt_reg + CNT_W'(1);
            end
      endcase
   end

   // divider: forced high by the clear, else toggled on each fall
   always_comb
   begin
      if (clear_nxt)
         clk_next = 1'b1;
      else if (src_fall)
         clk_next = ~clk_reg;
      else
         clk_next = clk_reg;
   end

   // source edge history, divider and sequence state
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         src_reg   <= 1'b0;
         clk_reg   <= 1'b0;
         state_reg <= st_run;
         cnt_reg   <= '0;
         fetch_reg <= 1'b0;
      end
      else
      begin
         src_reg   <= src;
         clk_reg   <= clk_next;
         state_reg <= state_next;
         cnt_reg   <= cnt_next;
         fetch_reg <= fetch_next;
      end
   end

   // fetch address held at the reset vector once a fetch starts
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         addr_reg <= '0;
      else if (fetch_next)
         addr_reg <= `FETCH_RESET_ADDR;
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   sequence req_seen_s;
      $rose(reset_req) && state_reg == st_run;
   endsequence

   sequence clear_seen_s;
      ##[1:CLEAR_BOUND] clear_act;
   endsequence

   sequence clear_end_s;
      $fell(clear_act) && clk_reg;
   endsequence

   div_fall_a: assert property (
      $fell(clk_reg) |-> $past(src_fall))
      else $error("system clock fell off a source fall");

   div_rise_a: assert property (
      $rose(clk_reg) |-> $past(src_fall) || clear_act)
      else $error("system clock rose without cause");

   clear_start_a: assert property (
      req_seen_s |-> clear_seen_s)
      else $error("reset request did not start a clear");

   clear_edges_a: assert property (
      $changed(clear_act) |-> $past(src_rise))
      else $error("clear pulse edge not on source rise");

   clear_high_a: assert property (
      clear_act |-> clk_reg)
      else $error("system clock low during clear");

   // the pin moves one clk after the fall, so that cycle is exempt
   after_clear_a: assert property (
      clear_end_s |-> clk_reg until $past(src_fall))
      else $error("system clock moved before the next fall");

   fetch_pulse_a: assert property (
      fetch_start |-> fetch_addr == `FETCH_RESET_ADDR ##1 !fetch_start)
      else $error("first fetch pulse or address wrong");

   fetch_cause_a: assert property (
      $rose(fetch_start) |-> $past(sys_toggle) && $past(last_half))
      else $error("first fetch not on the final half cycle");

   pin_clock_a: assert property (
      $changed(sys_clock_out) |-> $past(src_fall) || $rose(clear_act))
      else $error("clock pin moved without divider cause");

   // every stepping pulse must be followed by a fall of the pin
   fall_en_a: assert property (
      sys_fall_en |=> $fell(sys_clock_out))
      else $error("fall enable not followed by a clock fall");

   // the count restarts from zero on every release
   count_start_a: assert property (
      state_reg == st_hold && !reset_req |=>
         cnt_reg == '0 && state_reg == st_count)
      else $error("fetch count did not start from zero");

   // the vector stays put once the first fetch has named it
   addr_keep_a: assert property (
      fetch_addr == `FETCH_RESET_ADDR |=> fetch_addr == `FETCH_RESET_ADDR)
      else $error("first fetch address not held");
endmodule

/* File: rtl/clock_divider_reset_sync_consts.svh */
`ifndef CLOCK_DIVIDER_RESET_SYNC_CONSTS_SVH
`define CLOCK_DIVIDER_RESET_SYNC_CONSTS_SVH

// width of the processor address bus
`define FETCH_ADDR_W 20
// first instruction fetch address after reset
`define FETCH_RESET_ADDR 20'hFFFF0
// 6 1/2 system clock cycles, counted as system clock half cycles
`define FETCH_DELAY_HALVES 13
// asserted state of the two reset synchroniser stages after power-on
`define RESET_SYNC_INIT 1'b1
// bound, in clk cycles, from a reset request to the start of the clear
`define CLEAR_START_BOUND 1000

`endif

/* File: rtl/clock_divider_reset_sync_pkg.sv */
package clock_divider_reset_sync_pkg;
   // clock generator reset sequence
   typedef enum logic [2:0]
   {
      st_run,
      st_arm,
      st_clear,
      st_hold,
      st_count
   } gen_state_e;
endpackage

/* File: rtl/reset_sync_if.sv */
interface reset_sync_if;
   logic sys_fall_en;
   logic reset_req;
   logic reset_sync;

   modport gen
   (
      output sys_fall_en,
      output reset_req,
      input  reset_sync
   );

   modport sync
   (
      input  sys_fall_en,
      input  reset_req,
      output reset_sync
   );
endinterface

/* File: rtl/reset_synchroniser.sv */
`include "clock_divider_reset_sync_consts.svh"

module reset_synchroniser
(
   input  wire logic   clk,
   input  wire logic   rst_n,
   reset_sync_if.sync  rs
);
   logic stage1_reg;
   logic stage2_reg;

   // two stages stepped on the system clock falling edge only
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         stage1_reg <= `RESET_SYNC_INIT;
         stage2_reg <= `RESET_SYNC_INIT;
      end
      else if (rs.sys_fall_en)
      begin
         stage1_reg <= rs.reset_req;
         stage2_reg <= stage1_reg;
      end
   end

   assign rs.reset_sync = stage2_reg;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   sync_fall_a: assert property (
      $changed(stage2_reg) |-> $past(rs.sys_fall_en))
      else $error("reset output moved off a system clock fall");

   sync_two_a: assert property (
      $rose(stage2_reg) |-> $past(stage1_reg) && !$past(stage2_reg))
      else $error("reset output skipped the first stage");

   hold_stage_a: assert property (
      stage1_reg && rs.reset_req |=> stage1_reg)
      else $error("first stage dropped while reset held");

   hold_out_a: assert property (
      stage2_reg && stage1_reg |=> stage2_reg)
      else $error("reset output dropped while reset held");
endmodule

/* File: verification/freq_source.sv */
// free-running crystal or external frequency source
module freq_source
#(
   parameter int HALF = 2
)
(
   input  wire logic clk,
   input  wire logic rst_n,
   output logic      src
);
   timeunit 1ns;
   timeprecision 1ps;
   int cnt;

   // symmetric wave, moved off the sampling edge; half period >= 1 clk
   always @(negedge clk or negedge rst_n)
      if (!rst_n)
      begin
         cnt <= 0;
         src <= 1'b0;
      end
      else if (cnt == HALF - 1)
      begin
         cnt <= 0;
         src <= ~src;
      end
      else
         cnt <= cnt + 1;
endmodule

/* File: verification/clock_divider_reset_sync_bench.sv */
module clock_divider_reset_sync_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk = 0, rst_n = 0, use_ext_freq = 0, async_reset_in_n = 1;
   logic        osc_in, ext_freq_in, sys_clock_out, int_reset, reset_out;
   logic        fetch_start, src, src_q, fall_q, rise_q, sys_q, fall_en_q;
   logic        sys_fall_en;
   logic        chk_on = 0;
   logic [19:0] fetch_addr;
   int          err_total = 0, num_checks = 0, cyc = 0;

   always #5 clk = ~clk;
   assign src = use_ext_freq ? ext_freq_in : osc_in;

   freq_source #(.HALF(2)) osc (.clk(clk), .rst_n(rst_n), .src(osc_in));
   freq_source #(.HALF(3)) ext (.clk(clk), .rst_n(rst_n), .src(ext_freq_in));

   clock_divider_reset_sync DUT
   (
      .clk(clk), .rst_n(rst_n), .osc_in(osc_in), .ext_freq_in(ext_freq_in),
      .use_ext_freq(use_ext_freq), .async_reset_in_n(async_reset_in_n),
      .sys_clock_out(sys_clock_out), .sys_fall_en(sys_fall_en),
      .int_reset(int_reset),
      .reset_out(reset_out), .fetch_start(fetch_start),
      .fetch_addr(fetch_addr)
   );

   task automatic results;
      if (err_total == 0 && num_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task automatic chk(string what, logic [19:0] got, logic [19:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         err_total++;
         $display("wrong value %s: expected %h, seen %h", what, exp, got);
      end
   endtask

   // source edge history as the block samples it, plus the hang limit
   always @(posedge clk)
   begin
      src_q <= src;
      fall_q <= src_q & ~src;
      rise_q <= ~src_q & src;
      fall_en_q <= sys_fall_en;
      sys_q <= sys_clock_out;
      cyc <= cyc + 1;
      if (cyc == 3000)
      begin
         err_total++;
         results();
      end
   end

   // clock moves at the edge that sees a source fall, and only then;
   // a fall of the pin is flagged in the cycle before it
   always @(negedge clk)
      if (chk_on)
      begin
         chk("toggle", 20'(sys_clock_out ^ sys_q), 20'(fall_q));
         chk("fall_en", 20'(fall_en_q), 20'(sys_q & ~sys_clock_out));
      end

   // returns at the negedge after a source fall, so no edge is near
   task automatic wait_fall;
      repeat (20)
      begin
         @(posedge clk);
         #1;
         if (fall_q)
            break;
      end
      @(negedge clk);
   endtask

   task automatic t_divide(int h);
      int hi;
      hi = 0;
      repeat (40)
      begin
         @(negedge clk);
         if (sys_clock_out & !sys_q)
            break;
      end
      repeat (24 * h)
      begin
         if (sys_clock_out)
            hi++;
         @(negedge clk);
      end
      chk("duty", 20'(hi), 20'(12 * h));
   endtask

   task automatic t_clear(int h);
      wait_fall();
      chk_on = 0;
      async_reset_in_n = 1'b0;
      repeat (20)
      begin
         @(posedge clk);
         #1;
         if (rise_q)
            break;
      end
      // forced high across two source rises even though a fall lies between
      for (int k = 1; k <= 3 * h + 1; k++)
      begin
         @(posedge clk);
         @(negedge clk);
         chk("clear_clk", 20'(sys_clock_out), 20'(k < 3 * h));
      end
      chk_on = 1;
      repeat (30) @(negedge clk);
      repeat (16)
      begin
         @(negedge clk);
         chk("int_reset", 20'(int_reset), 20'h1);
         chk("reset_out", 20'(reset_out), 20'h1);
      end
   endtask

   task automatic t_release;
      int   n;
      logic hit;
      n = 0;
      hit = 0;
      wait_fall();
      async_reset_in_n = 1'b1;
      // thirteen source falls make six and a half system cycles
      while (!hit && cyc < 3000)
      begin
         @(posedge clk);
         #1;
         if (fall_q)
            n++;
         hit = (n == 13);
         chk("fetch_start", 20'(fetch_start), 20'(hit));
      end
      chk("fetch_addr", fetch_addr, 20'hFFFF0);
      chk("int_reset", 20'(int_reset), 20'h0);
      chk("reset_out", 20'(reset_out), 20'h0);
      @(posedge clk);
      #1;
      chk("fetch_pulse", 20'(fetch_start), 20'h0);
   endtask

   // one pass per clock source, mux switched while checking is paused
   initial
   begin
      repeat (8) @(negedge clk);
      rst_n = 1'b1;
      @(negedge clk);
      chk("fetch_addr", fetch_addr, 20'h0);
      chk("int_reset", 20'(int_reset), 20'h1);
      for (int s = 0; s < 2; s++)
      begin
         chk_on = 0;
         use_ext_freq = s[0];
         repeat (4) @(negedge clk);
         chk_on = 1;
         t_divide(s ? 3 : 2);
         t_clear(s ? 3 : 2);
         t_release();
      end
      results();
   end
endmodule
